/* File: design/motion_defines.vh */
`ifndef MOTION_DEFINES_VH
`define MOTION_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define MS_IN_NS 1000000
`define CYCLES_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define BRAKE_SCALE 120

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_CONTROL 5'd0
`define IDX_AUTO_SPEED 5'd1
`define IDX_MANUAL_SPEED 5'd2
`define IDX_LINEAR_TIME 5'd3
`define IDX_CURVE_TIME 5'd4
`define IDX_TORQUE_LIMIT 5'd5
`define IDX_EXCESS_WIDTH 5'd6
`define IDX_IN_POS_WIDTH 5'd7
`define IDX_NEAR_WIDTH 5'd8
`define IDX_ABS_SELECT 5'd9
`define IDX_SOFT_PLUS 5'd10
`define IDX_SOFT_MINUS 5'd11
`define IDX_POWEROFF_TOL 5'd12
`define IDX_MOVE_TARGET 5'd13
`define IDX_SAVED_POS 5'd14
`define IDX_STATION0 5'd15
`define CFG_COUNT 20
`define IDX_STATUS 5'd24
`define IDX_IRQ_STATUS 5'd25
`define IDX_IRQ_MASK 5'd26
`define IDX_POSITION 5'd27
`define STATION_COUNT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_AUTO_SPEED 32'h00001388
`define RST_MANUAL_SPEED 32'h000007d0
`define RST_LINEAR_TIME 32'h00000064
`define RST_CURVE_TIME 32'h00000001
`define RST_TORQUE_LIMIT 32'h000001f4
`define RST_EXCESS_WIDTH 32'h00000064
`define RST_IN_POS_WIDTH 32'h000001f4
`define RST_NEAR_WIDTH 32'h000003e8
`define RST_ABS_SELECT 32'h00000004
`define RST_SOFT_LIMIT 32'h000003e8

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define MODE_LSB 0
`define MODE_AUTO 3'h0
`define MODE_MANUAL 3'h1
`define MODE_JOG 3'h2
`define MODE_HANDWHEEL 3'h3
`define MODE_STOPPER 3'h4
`define ABS_DOG_BIT 1
`define ABS_MARK_BIT 2
`define ABS_ZERO_DIR_BIT 3
`define IRQ_EXCESS 0
`define IRQ_REJECT 1
`define IRQ_POWEROFF 2
`define IRQ_REACHED 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/speed_ramp.v */
`timescale 1ns/1ps
`include "motion_defines.vh"

module speed_ramp (
	input wire ref_clk,
	input wire rst_b,
	input wire [16:0] targetSpeed,
	input wire [16:0] clampSpeed,
	input wire [13:0] linearTime,
	input wire [9:0] curveTime,
	output reg [16:0] speed
);

	localparam [39:0] MS_CYCLES = `CYCLES_PER_MS;

	reg [39:0] acc;
	reg [9:0] jerk;
	reg [14:0] msCnt;
	wire curveMode;
	wire [9:0] curveHalf;
	wire [39:0] threshold;
	wire [39:0] accNext;
	wire [16:0] diff;
	wire speedUp;
	wire msTick;
	wire [47:0] approachLhs;
	wire [47:0] approachRhs;

	// ----------------------------------------
	// Slope arithmetic
	// ----------------------------------------
	// A curve time of one means a plain straight ramp.
	assign curveMode = (curveTime > 10'h001);
	assign curveHalf = curveMode ? {1'b0, curveTime[9:1]} : 10'h001;
	// The clamp speed is reached after the linear time at full slope.
	assign threshold = {26'h0, linearTime} * MS_CYCLES * {30'h0, curveHalf};
	assign accNext = acc + {23'h0, clampSpeed} * {30'h0, jerk};
	assign speedUp = (targetSpeed > speed);
	assign diff = speedUp ? targetSpeed - speed : speed - targetSpeed;
	assign msTick = (msCnt == MS_CYCLES[14:0] - 15'h0001);
	// Speed still to be gained while the slope winds down to zero.
	assign approachLhs = {31'h0, diff} * 48'h2 * {38'h0, curveHalf} * {34'h0, linearTime};
	assign approachRhs = {31'h0, clampSpeed} * {38'h0, jerk} * {38'h0, jerk};

	// Millisecond timebase for the slope shaping.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			msCnt <= 15'h0000;
		else if (msTick)
			msCnt <= 15'h0000;
		else
			msCnt <= msCnt + 15'h0001;
	end

	// Speed follows the target one unit at a time at the programmed slope.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			speed <= 17'h00000;
			acc <= 40'h0;
			jerk <= 10'h001;
		end
		else if (diff == 17'h00000)
		begin
			acc <= 40'h0;
			jerk <= curveMode ? 10'h000 : 10'h001;
		end
		else
		begin
			if (accNext >= threshold)
			begin
				acc <= accNext - threshold;
				speed <= speedUp ? speed + 17'h00001 : speed - 17'h00001;
			end
			else
				acc <= accNext;
			// The slope rises and falls gradually to round both ends.
			if (!curveMode)
				jerk <= 10'h001;
			else if (msTick && approachLhs <= approachRhs && jerk > 10'h001)
				jerk <= jerk - 10'h001;
			else if (msTick && jerk < curveHalf)
				jerk <= jerk + 10'h001;
		end
	end

endmodule // speed_ramp

/* File: design/indexing_axis_motion.v */
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "motion_defines.vh"

// Summary of operation
// - Auto feed uses group-one auto speed; every speed is clamped to it.
// - Manual and jog moves use the group-one manual speed.
// - Linear ramp reaches clamp speed in the linear time; slower moves share slope.
// - With both times set the ramp is S-shaped; linear time sets the slope of the straight part.
// - Curve time is total rounded time; a value of one gives a straight ramp.
// - Handwheel mode ramps linearly using the curve time as time constant.
// - Motor torque is limited to the group-one torque percentage, default full.
// - Stopper mode applies the group-one torque limit on its approach.
// - Excess-error alarm when position droop exceeds the group-one width.
// - Position-reached is high while position is within width of any station.
// - In automatic mode the auto position-reached output follows position-reached.
// - Both reached outputs drop once position leaves the station by over the width.
// - A select field picks dog, stopper or marked-point init and zero direction.
// - Near output is high while position is within the near width of any station.
module indexing_axis_motion (
	input wire ref_clk,
	input wire rst_b,
	input wire [6:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [6:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] machinePosition,
	input wire [31:0] positionDroop,
	output reg [17:0] velocityCommand,
	output reg [8:0] torqueLimitOut,
	output reg position_reached_out,
	output reg auto_position_reached_out,
	output reg nearPositionOut,
	output reg excessErrorAlarm,
	output reg poweroffMoveAlarm,
	output reg absDogMethod,
	output reg absStopperMethod,
	output reg absMarkMethod,
	output reg absZeroMinus,
	output reg irq
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN = 3'b010;
	localparam [2:0] ST_BRAKE = 3'b100;

	integer i;
	reg [31:0] cfg [0:`CFG_COUNT-1];
	reg [31:0] posMeta;
	reg [31:0] posSync;
	reg [31:0] droopMeta;
	reg [31:0] droopSync;
	reg [6:0] awAddr;
	reg awHave;
	reg [31:0] wData;
	reg [3:0] wStrb;
	reg wHave;
	reg [2:0] state;
	reg [2:0] next_state;
	reg moveDir;
	reg [31:0] moveTarget;
	reg [3:0] irqStatus;
	reg [3:0] irqMask;
	reg [31:0] readValue;
	reg readOk;
	wire [4:0] wIdx;
	wire [4:0] rIdx;
	wire [31:0] wMask;
	wire doWrite;
	wire writeMapped;
	wire targetWrite;
	wire savedWrite;
	wire [2:0] mode;
	wire [16:0] group1_auto_speed;
	wire [16:0] group1_manual_speed;
	wire [13:0] group1_linear_ramp_time;
	wire [9:0] group1_curve_ramp_time;
	wire [8:0] group1_torque_limit;
	wire [31:0] group1_excess_error_width;
	wire [31:0] group1_in_position_width;
	wire [31:0] group1_near_width;
	wire [3:0] abs_init_method_select;
	wire [31:0] poweroff_move_tolerance;
	wire [16:0] feedrate;
	wire [16:0] rampTarget;
	wire [13:0] rampLinear;
	wire [9:0] rampCurve;
	wire [16:0] rampSpeed;
	wire [31:0] remaining;
	wire [63:0] brakeLhs;
	wire [63:0] brakeRhs;
	wire softEnable;
	wire softViolation;
	wire excessNow;
	wire poweroffNow;
	wire [`STATION_COUNT-1:0] inStation;
	wire [`STATION_COUNT-1:0] nearStation;
	wire reachedNow;
	wire [3:0] irqEvents;

	// Magnitude of the signed difference of two positions.
	function [31:0] absDiff;
		input [31:0] a;
		input [31:0] b;
		reg [31:0] d;
		begin
			d = a - b;
			absDiff = d[31] ? (~d + 32'h00000001) : d;
		end
	endfunction

	// Reset value of each configuration word.
	function [31:0] cfgReset;
		input integer idx;
		begin
			case (idx)
				1: cfgReset = `RST_AUTO_SPEED;
				2: cfgReset = `RST_MANUAL_SPEED;
				3: cfgReset = `RST_LINEAR_TIME;
				4: cfgReset = `RST_CURVE_TIME;
				5: cfgReset = `RST_TORQUE_LIMIT;
				6: cfgReset = `RST_EXCESS_WIDTH;
				7: cfgReset = `RST_IN_POS_WIDTH;
				8: cfgReset = `RST_NEAR_WIDTH;
				9: cfgReset = `RST_ABS_SELECT;
				10: cfgReset = `RST_SOFT_LIMIT;
				11: cfgReset = `RST_SOFT_LIMIT;
				default: cfgReset = 32'h00000000;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Servo feedback is sampled twice before any logic looks at it.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			posMeta <= 32'h00000000;
			posSync <= 32'h00000000;
			droopMeta <= 32'h00000000;
			droopSync <= 32'h00000000;
		end
		else
		begin
			posMeta <= machinePosition;
			posSync <= posMeta;
			droopMeta <= positionDroop;
			droopSync <= droopMeta;
		end
	end

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	assign mode = cfg[`IDX_CONTROL][`MODE_LSB+2:`MODE_LSB];
	assign group1_auto_speed = cfg[`IDX_AUTO_SPEED][16:0];
	assign group1_manual_speed = cfg[`IDX_MANUAL_SPEED][16:0];
	assign group1_linear_ramp_time = cfg[`IDX_LINEAR_TIME][13:0];
	assign group1_curve_ramp_time = cfg[`IDX_CURVE_TIME][9:0];
	assign group1_torque_limit = cfg[`IDX_TORQUE_LIMIT][8:0];
	assign group1_excess_error_width = cfg[`IDX_EXCESS_WIDTH];
	assign group1_in_position_width = cfg[`IDX_IN_POS_WIDTH];
	assign group1_near_width = cfg[`IDX_NEAR_WIDTH];
	assign abs_init_method_select = cfg[`IDX_ABS_SELECT][3:0];
	assign poweroff_move_tolerance = cfg[`IDX_POWEROFF_TOL];

	// ----------------------------------------
	// Register bus write path
	// ----------------------------------------
	assign wIdx = awAddr[6:2];
	assign doWrite = awHave && wHave && !s_axi_bvalid;
	assign writeMapped = (wIdx < `CFG_COUNT) || (wIdx == `IDX_IRQ_STATUS) ||
		(wIdx == `IDX_IRQ_MASK) || (wIdx == `IDX_STATUS) || (wIdx == `IDX_POSITION);
	assign wMask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
	assign targetWrite = doWrite && (wIdx == `IDX_MOVE_TARGET);
	assign savedWrite = doWrite && (wIdx == `IDX_SAVED_POS);

	// Address and data are taken in either order; the answer follows both.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			awHave <= 1'b0;
			wHave <= 1'b0;
			awAddr <= 7'h00;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awAddr <= s_axi_awaddr;
				awHave <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				wHave <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				awHave <= 1'b0;
				wHave <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeMapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Configuration words take the enabled byte lanes of a write.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (i = 0; i < `CFG_COUNT; i = i + 1)
				cfg[i] <= cfgReset(i);
		end
		else if (doWrite && wIdx < `CFG_COUNT)
			cfg[wIdx] <= (cfg[wIdx] & ~wMask) | (wData & wMask);
	end

	// ----------------------------------------
	// Register bus read path
	// ----------------------------------------
	assign rIdx = s_axi_araddr[6:2];

	// Read data selection; unmapped words answer with an error.
	always @*
	begin
		readOk = 1'b1;
		readValue = 32'h00000000;
		if (rIdx < `CFG_COUNT)
			readValue = cfg[rIdx];
		else if (rIdx == `IDX_STATUS)
			readValue = {20'h00000, state, absDogMethod, poweroffMoveAlarm,
				excessErrorAlarm, nearPositionOut, auto_position_reached_out,
				position_reached_out, moveDir, 2'h0};
		else if (rIdx == `IDX_IRQ_STATUS)
			readValue = {28'h0000000, irqStatus};
		else if (rIdx == `IDX_IRQ_MASK)
			readValue = {28'h0000000, irqMask};
		else if (rIdx == `IDX_POSITION)
			readValue = posSync;
		else
			readOk = 1'b0;
	end

	// One read at a time, answered the cycle after the address is taken.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= readValue;
			s_axi_rresp <= readOk ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Move sequencing
	// ----------------------------------------
	// Every feed is capped at the automatic speed.
	assign feedrate = (mode == `MODE_AUTO) ? group1_auto_speed :
		((group1_manual_speed > group1_auto_speed) ? group1_auto_speed :
		group1_manual_speed);
	assign rampTarget = (state == ST_RUN) ? feedrate : 17'h00000;
	// Handwheel feed uses the curve time as a plain straight ramp.
	assign rampLinear = (mode == `MODE_HANDWHEEL) ? {4'h0, group1_curve_ramp_time} :
		group1_linear_ramp_time;
	assign rampCurve = (mode == `MODE_HANDWHEEL) ? 10'h001 : group1_curve_ramp_time;
	assign softEnable = (cfg[`IDX_SOFT_PLUS] != cfg[`IDX_SOFT_MINUS]);
	assign softViolation = softEnable &&
		(($signed(wData) > $signed(cfg[`IDX_SOFT_PLUS])) ||
		($signed(wData) < $signed(cfg[`IDX_SOFT_MINUS])));
	assign remaining = absDiff(moveTarget, posSync);
	// Stopping distance in position units grows with the square of speed.
	assign brakeLhs = {32'h0, remaining} * 64'd`BRAKE_SCALE * {47'h0, group1_auto_speed};
	assign brakeRhs = {47'h0, rampSpeed} * {47'h0, rampSpeed} * {50'h0, rampLinear};

	speed_ramp ramp (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.targetSpeed(rampTarget),
		.clampSpeed(group1_auto_speed),
		.linearTime(rampLinear),
		.curveTime(rampCurve),
		.speed(rampSpeed)
	);

	// Next state of the move sequencer.
	always @*
	begin
		case (state)
			ST_IDLE: next_state = (targetWrite && !softViolation) ? ST_RUN : ST_IDLE;
			ST_RUN: next_state = (brakeLhs <= brakeRhs ||
				(moveDir != $signed(moveTarget) > $signed(posSync))) ? ST_BRAKE : ST_RUN;
			ST_BRAKE: next_state = (rampSpeed == 17'h00000) ? ST_IDLE : ST_BRAKE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencer state and the accepted move.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			moveDir <= 1'b0;
			moveTarget <= 32'h00000000;
		end
		else
		begin
			state <= next_state;
			if (state == ST_IDLE && targetWrite && !softViolation)
			begin
				moveTarget <= wData;
				moveDir <= ($signed(wData) > $signed(posSync));
			end
		end
	end

	// ----------------------------------------
	// Supervision
	// ----------------------------------------
	assign excessNow = (absDiff(droopSync, 32'h00000000) > group1_excess_error_width);
	assign poweroffNow = (poweroff_move_tolerance != 32'h00000000) &&
		(absDiff(posSync, wData) > poweroff_move_tolerance);

	genvar s;
	generate
		for (s = 0; s < `STATION_COUNT; s = s + 1)
		begin : station_cmp
			assign inStation[s] = (absDiff(posSync, cfg[`IDX_STATION0 + s]) <=
				group1_in_position_width);
			assign nearStation[s] = (absDiff(posSync, cfg[`IDX_STATION0 + s]) <=
				group1_near_width);
		end
	endgenerate

	assign reachedNow = |inStation;
	assign irqEvents = {reachedNow && !position_reached_out,
		savedWrite && poweroffNow,
		targetWrite && (softViolation || state != ST_IDLE),
		excessNow && !excessErrorAlarm};

	// Registered outputs toward the servo amplifier.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			velocityCommand <= 18'h00000;
			torqueLimitOut <= 9'h000;
			position_reached_out <= 1'b0;
			auto_position_reached_out <= 1'b0;
			nearPositionOut <= 1'b0;
			excessErrorAlarm <= 1'b0;
			poweroffMoveAlarm <= 1'b0;
			absDogMethod <= 1'b0;
			absStopperMethod <= 1'b0;
			absMarkMethod <= 1'b0;
			absZeroMinus <= 1'b0;
		end
		else
		begin
			velocityCommand <= moveDir ? {1'b0, rampSpeed} : (18'h00000 - {1'b0, rampSpeed});
			torqueLimitOut <= group1_torque_limit;
			position_reached_out <= reachedNow;
			auto_position_reached_out <= reachedNow && (mode == `MODE_AUTO);
			nearPositionOut <= |nearStation;
			excessErrorAlarm <= excessNow;
			if (savedWrite)
				poweroffMoveAlarm <= poweroffNow;
			absDogMethod <= abs_init_method_select[`ABS_DOG_BIT];
			absStopperMethod <= !abs_init_method_select[`ABS_DOG_BIT] &&
				!abs_init_method_select[`ABS_MARK_BIT];
			absMarkMethod <= !abs_init_method_select[`ABS_DOG_BIT] &&
				abs_init_method_select[`ABS_MARK_BIT];
			absZeroMinus <= abs_init_method_select[`ABS_ZERO_DIR_BIT];
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Sticky event bits; a new event outranks a clearing write.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irqStatus <= 4'h0;
			irqMask <= 4'h0;
			irq <= 1'b0;
		end
		else
		begin
			if (doWrite && wIdx == `IDX_IRQ_STATUS && wStrb[0])
				irqStatus <= (irqStatus & ~wData[3:0]) | irqEvents;
			else
				irqStatus <= irqStatus | irqEvents;
			if (doWrite && wIdx == `IDX_IRQ_MASK && wStrb[0])
				irqMask <= wData[3:0];
			irq <= |(irqStatus & irqMask);
		end
	end

endmodule // indexing_axis_motion

/* File: verification/indexing_axis_motion_asserts.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module indexing_axis_motion_asserts (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [17:0] velocityCommand,
	input wire logic position_reached_out,
	input wire logic auto_position_reached_out,
	input wire logic absDogMethod,
	input wire logic absStopperMethod,
	input wire logic absMarkMethod
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// A write is taken when address and data go in together; its answer follows shortly.
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wrAnswer;
		##[1:2] s_axi_bvalid;
	endsequence

	chk_write_answer: assert property (wrTaken |-> wrAnswer)
		else $error("write response did not follow a taken write");
	chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stayed after its handshake");
	chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted while a response is pending");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data did not follow a taken read");
	chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read data stayed after its handshake");
	chk_auto_follows: assert property (auto_position_reached_out |-> position_reached_out)
		else $error("auto reached high without reached");
	chk_ramp_step: assert property ($past(rst_b) |-> (velocityCommand - $past(velocityCommand))
		inside {18'h00000, 18'h00001, 18'h3ffff})
		else $error("speed changed by more than one step");
	chk_abs_onehot: assert property ($past(rst_b) |->
		$onehot({absDogMethod, absStopperMethod, absMarkMethod}))
		else $error("not exactly one init method selected");
endmodule // indexing_axis_motion_asserts

bind indexing_axis_motion indexing_axis_motion_asserts indexing_axis_motion_asserts_inst (.*);

/* File: verification/servo_axis_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Servo amplifier and motor stand-in
// ----------------------------------------
module servo_axis_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [17:0] velocityCommand,
	input wire logic [8:0] torqueLimitOut,
	input wire logic [31:0] setPos,
	input wire logic [31:0] setDroop,
	output logic [31:0] machinePosition,
	output logic [31:0] positionDroop
);
	// Speed in units per minute accumulated per cycle that makes one thousandth of a unit of travel.
	localparam int STEP = 1200000;
	int frac;
	int moved;

	// The axis travels at the commanded speed; with no torque allowed it cannot move.
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frac <= 0;
			moved <= 0;
		end
		else if (torqueLimitOut != 9'h000)
		begin
			frac <= (frac + int'($signed(velocityCommand))) % STEP;
			moved <= moved + (frac + int'($signed(velocityCommand))) / STEP;
		end
	end

	// Position seen by the controller is the set point plus the travel made.
	assign machinePosition = setPos + moved;
	assign positionDroop = setDroop;
endmodule // servo_axis_model

/* File: verification/indexing_axis_motion_bench.sv */
`timescale 1ns/1ps
`include "motion_defines.vh"

module indexing_axis_motion_bench;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] s_axi_awaddr = 7'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [6:0] s_axi_araddr = 7'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [31:0] machinePosition;
	logic [31:0] positionDroop;
	logic [17:0] velocityCommand;
	logic [8:0] torqueLimitOut;
	logic position_reached_out, auto_position_reached_out, nearPositionOut;
	logic excessErrorAlarm, poweroffMoveAlarm, irq;
	logic absDogMethod, absStopperMethod, absMarkMethod, absZeroMinus;
	logic [31:0] setPos = 32'h00000000, setDroop = 32'h00000000;
	logic [31:0] rdVal;
	int n_fail = 0, checks_done = 0;
	localparam logic [31:0] cfgVal [9] = '{32'h00001388, 32'h000007d0, 32'h00000064,
		32'h00000001, 32'h000001f4, 32'h00000064, 32'h000001f4, 32'h000003e8, 32'h00000004};
	localparam logic [3:0] absSel [5] = '{4'h2, 4'h0, 4'h4, 4'hc, 4'ha};
	localparam logic [3:0] absExp [5] = '{4'h8, 4'h4, 4'h2, 4'h3, 4'h9};
	localparam logic [2:0] posMode [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
	localparam logic [31:0] posTab [8] = '{32'h00000000, 32'h000001f4, 32'h000001f5,
		32'h000003e8, 32'h000003e9, 32'hfffffe70, 32'h00001388, 32'h00000000};
	localparam logic [2:0] posExp [8] = '{3'h7, 3'h7, 3'h1, 3'h1, 3'h0, 3'h7, 3'h7, 3'h5};

	// ----------------------------------------
	// Design, far side and clock
	// ----------------------------------------
	indexing_axis_motion indexing_axis_motion_inst (.*);
	servo_axis_model servo_axis_model_inst (.*);

	// Free-running 20 MHz clock.
	always #25 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compares one value and counts the outcome.
	task automatic check(input string what, input logic [31:0] expv, input logic [31:0] seen);
		checks_done++;
		if (seen !== expv)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, expv, seen);
		end
	endtask

	// Bus write; address and data are released as each is taken.
	task automatic wr(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge ref_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
			s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("write response", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	// Bus read into rdVal.
	task automatic rd(input logic [4:0] idx, input logic [1:0] er = 2'h0);
		@(posedge ref_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rdVal = s_axi_rdata;
		check("read response", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	// Lets synchronised inputs reach the registered outputs.
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Main sequence: defaults, decoding, alarms, stations, limits and a long move.
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			rd(5'(i + 1));
			check("reset value", cfgVal[i], rdVal);
		end
		check("torque out", 32'h000001f4, {23'h0, torqueLimitOut});
		wr(`IDX_TORQUE_LIMIT, 32'h000000fa);
		wr(`IDX_CONTROL, 32'h00000004);
		settle(3);
		check("stopper torque", 32'h000000fa, {23'h0, torqueLimitOut});
		for (int i = 0; i < 5; i++)
		begin
			wr(`IDX_ABS_SELECT, {28'h0, absSel[i]});
			settle(3);
			check("abs decode", {28'h0, absExp[i]},
				{28'h0, absDogMethod, absStopperMethod, absMarkMethod, absZeroMinus});
		end
		rd(5'd20, 2'h2);
		check("unmapped read", 32'h00000000, rdVal);
		wr(5'd21, 32'h00000001, 2'h2);
		wr(`IDX_IRQ_STATUS, 32'h0000000f);
		for (int m = 1; m >= 0; m--)
		begin
			wr(`IDX_IRQ_MASK, m);
			setDroop <= 32'h00000064;
			settle(6);
			check("alarm at width", 32'h0, {31'h0, excessErrorAlarm});
			setDroop <= 32'h00000065;
			settle(6);
			check("alarm past width", 32'h1, {31'h0, excessErrorAlarm});
			check("irq masked", m, {31'h0, irq});
			setDroop <= 32'h00000000;
			rd(`IDX_IRQ_STATUS);
			check("excess event", 32'h00000001, rdVal);
			wr(`IDX_IRQ_STATUS, 32'h00000001);
			settle(3);
			check("irq cleared", 32'h0, {31'h0, irq});
		end
		wr(`IDX_STATION0 + 5'd1, 32'h00001388);
		for (int i = 0; i < 8; i++)
		begin
			wr(`IDX_CONTROL, {29'h0, posMode[i]});
			setPos <= posTab[i];
			settle(6);
			check("reached outputs", {29'h0, posExp[i]}, {29'h0, position_reached_out,
				auto_position_reached_out, nearPositionOut});
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(`IDX_POWEROFF_TOL, (i == 0) ? 32'h00000000 : 32'h00000064);
			wr(`IDX_SAVED_POS, (i == 2) ? 32'h00000032 : 32'h00001388);
			settle(3);
			check("power-off alarm", (i == 1), {31'h0, poweroffMoveAlarm});
		end
		wr(`IDX_SOFT_MINUS, 32'hfffffc18);
		wr(`IDX_CONTROL, 32'h00000003);
		wr(`IDX_IRQ_STATUS, 32'h0000000f);
		wr(`IDX_MOVE_TARGET, 32'h000007d0);
		rd(`IDX_IRQ_STATUS);
		check("move refused", 32'h2, rdVal & 32'h2);
		check("no motion", 32'h0, {14'h0, velocityCommand});
		wr(`IDX_SOFT_MINUS, 32'h000003e8);
		wr(`IDX_IRQ_STATUS, 32'h0000000f);
		wr(`IDX_MOVE_TARGET, 32'h000f4240);
		rd(`IDX_IRQ_STATUS);
		check("move taken", 32'h0, rdVal & 32'h2);
		settle(396);
		check("handwheel slope", 32'h1, (velocityCommand >= 18'd90 && velocityCommand <= 18'd110));
		wr(`IDX_LINEAR_TIME, 32'h00000001);
		wr(`IDX_CONTROL, 32'h00000001);
		settle(200);
		check("ramp slope", 32'h1, (velocityCommand >= 18'd140 && velocityCommand <= 18'd160));
		settle(9600);
		check("manual feed", 32'h000007d0, {14'h0, velocityCommand});
		wr(`IDX_MANUAL_SPEED, 32'h00002328);
		settle(13000);
		check("clamped feed", 32'h00001388, {14'h0, velocityCommand});
		complete_run;
	end

	// Watchdog: the sequence needs about 23500 cycles.
	initial
	begin
		#2500000;
		n_fail++;
		complete_run;
	end
endmodule // indexing_axis_motion_bench
